// ==== ccp_unit_defines.svh ====
/*
 * Register offsets, field positions, reset values and timing counts of the
 * capture/compare unit. Assumes inclusion by bare name, before any module.
 */
`ifndef CCP_UNIT_DEFINES_SVH
`define CCP_UNIT_DEFINES_SVH

// ---------------------------------------------------------------------------
// register byte offsets (one 32-bit word each)
// ---------------------------------------------------------------------------
`define OFS_CONTROL      8'h00
`define OFS_CAP_SEL      8'h04
`define OFS_VALUE_LOW    8'h08
`define OFS_VALUE_HIGH   8'h0C
`define OFS_TIMER_SEL    8'h10
`define OFS_STATUS       8'h14

// ---------------------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------------------
`define CTL_MODE_LSB     0
`define CTL_MODE_MSB     3
`define CTL_OPEN_DRAIN   4
`define CTL_ADC_TRIG_EN  5
`define CTL_ENABLE       7
`define CTL_RESET        8'h00

// status register fields
`define STS_IRQ_FLAG     0
`define STS_OUT_LEVEL    1

// mode encodings (0000 off)
`define MODE_OFF         4'h0
`define MODE_TOG_CLR     4'h1
`define MODE_TOG         4'h2
`define MODE_CAP_ANY     4'h3
`define MODE_CAP_FALL    4'h4
`define MODE_CAP_RISE    4'h5
`define MODE_CAP_RISE4   4'h6
`define MODE_CAP_RISE16  4'h7
`define MODE_SET         4'h8
`define MODE_CLR         4'h9
`define MODE_PULSE       4'hA
`define MODE_PULSE_CLR   4'hB

// prescaler terminal counts
`define PRE_DIV4_LAST    4'h3
`define PRE_DIV16_LAST   4'hF

`endif

// ==== ccp_unit_pkg.sv ====
/*
 * Types shared by the capture/compare unit.
 * Assumes the defines header for encodings.
 */
package ccp_unit_pkg;
	// mode class of the unit
	typedef enum logic [1:0] {
		CLASS_OFF     = 2'h0,
		CLASS_CAPTURE = 2'h1,
		CLASS_COMPARE = 2'h3
	} mode_class_t;
	typedef logic [15:0] count_t;
endpackage : ccp_unit_pkg

// ==== timer_capture_compare_unit.sv ====
/*
 * Capture/compare unit tied to a selected 16-bit timer, with a classic
 * Wishbone register slave. Assumes the timers, trigger sources and pin
 * direction logic sit outside, all on clk_i except the raw pin/cell inputs.
 */
// The Wishbone slave port and the register addresses are this design's own decisions.
// Summary of operation
// - the 16-bit value is reached as separate low and high byte registers
// - one of three odd timers is selected; units may share a timer
// - output pin driver can be open-drain instead of push-pull
// - a capture event copies the whole selected timer count into the value
// - mode picks falling, rising, 4th rising, 16th rising, or any edge
// - each capture sets the irq flag; only software clears it
// - a newer capture overwrites the value with no overrun indication
// - 3-bit select picks logic cells, pin change, comparators or pin
// - the pin level is watched even while the pin is an output
// - prescaler cleared when disabled, not capturing, or reset
// - changing prescaler while capturing keeps the prescaler count
// - capture follows the timer count, frozen or running, through sleep
// - in compare mode the value is compared continuously with the timer
// - match action: toggle/clear, toggle, set, clear, pulse, pulse/clear
// - each match sets the flag and, if chosen, triggers a conversion
// - modes 0001 and 1011 reset the timer on a match
// - clearing the control register forces the output latch low
// - the output is also offered to other on-chip peripherals
`include "ccp_unit_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module timer_capture_compare_unit (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	// wishbone slave
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [31:0]           wb_dat_i,
	input  wire logic [3:0]            wb_sel_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	output logic                       wb_err_o,
	// timers 1, 3, 5 and their increment enables
	input  wire ccp_unit_pkg::count_t  timer1_count_i,
	input  wire ccp_unit_pkg::count_t  timer3_count_i,
	input  wire ccp_unit_pkg::count_t  timer5_count_i,
	input  wire logic [2:0]            timer_tick_i,
	// trigger sources
	input  wire logic                  capture_pin_i,
	input  wire logic                  pin_change_event_i,
	input  wire logic                  comparator_one_out_i,
	input  wire logic                  comparator_two_out_i,
	input  wire logic                  logic_cell_one_out_i,
	input  wire logic                  logic_cell_two_out_i,
	input  wire logic                  logic_cell_three_out_i,
	input  wire logic                  logic_cell_four_out_i,
	input  wire logic                  adc_source_is_me_i,
	// results
	output logic [2:0]                 timer_clear_o,
	output logic                       adc_trigger_o,
	output logic                       unit_irq_flag_o,
	output logic                       unit_out_o,
	output logic                       pin_out_o,
	output logic                       pin_oe_o
);
	import ccp_unit_pkg::*;

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	logic [7:0]  unit_control_reg_q;
	logic [2:0]  capture_input_select_reg_q;
	logic [1:0]  timer_assign_sel_q;
	count_t      capture_compare_value_q;
	logic        irq_flag_q;
	logic        out_latch_q;
	logic        pulse_q;
	logic [3:0]  pre_cnt_q;
	logic [2:0]  src_sync_q;
	logic [2:0]  timer_sel_tick_q;
	logic        match_seen_q;

	// mode decode, used by both capture and compare paths
	function automatic mode_class_t class_of(input logic [3:0] m);
		unique case (m)
			`MODE_CAP_ANY, `MODE_CAP_FALL, `MODE_CAP_RISE,
			`MODE_CAP_RISE4, `MODE_CAP_RISE16: class_of = CLASS_CAPTURE;
			`MODE_OFF, 4'hC, 4'hD, 4'hE, 4'hF: class_of = CLASS_OFF;
			default:                           class_of = CLASS_COMPARE;
		endcase
	endfunction : class_of

	wire [3:0]   mode       = unit_control_reg_q[`CTL_MODE_MSB:`CTL_MODE_LSB];
	wire         enabled    = unit_control_reg_q[`CTL_ENABLE];
	wire mode_class_t mclass = enabled ? class_of(mode) : CLASS_OFF;
	wire         capturing  = (mclass == CLASS_CAPTURE);
	wire         comparing  = (mclass == CLASS_COMPARE);

	// ------------------------------------------------------------------
	// wishbone decode
	// ------------------------------------------------------------------
	wire         req        = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	wire         hit_ctl    = (wb_adr_i == `OFS_CONTROL);
	wire         hit_cap    = (wb_adr_i == `OFS_CAP_SEL);
	wire         hit_lo     = (wb_adr_i == `OFS_VALUE_LOW);
	wire         hit_hi     = (wb_adr_i == `OFS_VALUE_HIGH);
	wire         hit_tmr    = (wb_adr_i == `OFS_TIMER_SEL);
	wire         hit_sts    = (wb_adr_i == `OFS_STATUS);
	wire         mapped     = hit_ctl | hit_cap | hit_lo | hit_hi | hit_tmr | hit_sts;
	wire         wr         = req & wb_we_i & mapped & wb_sel_i[0];
	wire         wr_ctl     = wr & hit_ctl;
	wire         ctl_zero   = wr_ctl & (wb_dat_i[7:0] == `CTL_RESET);

	// ------------------------------------------------------------------
	// timer selection: odd timers only
	// ------------------------------------------------------------------
	wire count_t sel_count  = (timer_assign_sel_q == 2'h1) ? timer3_count_i :
	                          (timer_assign_sel_q == 2'h2) ? timer5_count_i :
	                          timer1_count_i;
	wire         sel_tick   = (timer_assign_sel_q == 2'h1) ? timer_tick_i[1] :
	                          (timer_assign_sel_q == 2'h2) ? timer_tick_i[2] :
	                          timer_tick_i[0];

	// ------------------------------------------------------------------
	// capture source and edge detection
	// ------------------------------------------------------------------
	// pin is watched whatever its direction, so port writes can capture
	wire         src_raw    = (capture_input_select_reg_q == 3'h7) ? logic_cell_four_out_i :
	                          (capture_input_select_reg_q == 3'h6) ? logic_cell_three_out_i :
	                          (capture_input_select_reg_q == 3'h5) ? logic_cell_two_out_i :
	                          (capture_input_select_reg_q == 3'h4) ? logic_cell_one_out_i :
	                          (capture_input_select_reg_q == 3'h3) ? pin_change_event_i :
	                          (capture_input_select_reg_q == 3'h2) ? comparator_two_out_i :
	                          (capture_input_select_reg_q == 3'h1) ? comparator_one_out_i :
	                          capture_pin_i;

	// three stages; a change counts when the last two differ
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_sync_q <= 3'h0;
		end else begin
			src_sync_q <= {src_sync_q[1:0], src_raw};
		end
	end

	wire         rise       = src_sync_q[1] & ~src_sync_q[2];
	wire         fall       = ~src_sync_q[1] & src_sync_q[2];
	wire         pre_last4  = (pre_cnt_q == `PRE_DIV4_LAST);
	wire         pre_last16 = (pre_cnt_q == `PRE_DIV16_LAST);
	wire         cap_event  = capturing & (
	                          ((mode == `MODE_CAP_FALL)   & fall) |
	                          ((mode == `MODE_CAP_RISE)   & rise) |
	                          ((mode == `MODE_CAP_ANY)    & (rise | fall)) |
	                          ((mode == `MODE_CAP_RISE4)  & rise & pre_last4) |
	                          ((mode == `MODE_CAP_RISE16) & rise & pre_last16));

	// prescaler: cleared when off or not capturing, kept across changes
	always_ff @(posedge clk_i) begin
		if (rst_i || !capturing) begin
			pre_cnt_q <= 4'h0;
		end else if (rise) begin
			// wraps per setting; a switch keeps the count
			pre_cnt_q <= (mode == `MODE_CAP_RISE4 && pre_last4) ? 4'h0 : pre_cnt_q + 4'h1;
		end
	end

	// ------------------------------------------------------------------
	// compare
	// ------------------------------------------------------------------
	// match fires once per equality window, when the timer reaches the value
	wire         equal      = (sel_count == capture_compare_value_q);
	wire         match      = comparing & equal & ~match_seen_q;
	wire         clr_mode   = (mode == `MODE_TOG_CLR) | (mode == `MODE_PULSE_CLR);
	wire         pulse_mode = (mode == `MODE_PULSE) | (mode == `MODE_PULSE_CLR);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			match_seen_q <= 1'b0;
		end else begin
			match_seen_q <= comparing & equal;
		end
	end

	// output latch actions; a zero control write forces it low
	always_ff @(posedge clk_i) begin
		if (rst_i || ctl_zero) begin
			out_latch_q <= 1'b0;
			pulse_q     <= 1'b0;
		end else if (match) begin
			unique case (mode)
				`MODE_TOG_CLR, `MODE_TOG: out_latch_q <= ~out_latch_q;
				`MODE_SET:                out_latch_q <= 1'b1;
				`MODE_CLR:                out_latch_q <= 1'b0;
				default:                  out_latch_q <= out_latch_q;
			endcase
			pulse_q <= pulse_mode;
		end else if (pulse_q && sel_tick) begin
			pulse_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// outputs to timer, adc and pin
	// ------------------------------------------------------------------
	wire         drive_hi   = out_latch_q | pulse_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_clear_o   <= 3'h0;
			adc_trigger_o   <= 1'b0;
			unit_out_o      <= 1'b0;
			pin_out_o       <= 1'b0;
			pin_oe_o        <= 1'b0;
			timer_sel_tick_q <= 3'h0;
		end else begin
			timer_sel_tick_q <= timer_tick_i;
			timer_clear_o <= (match && clr_mode) ? (3'h1 << timer_assign_sel_q) : 3'h0;
			adc_trigger_o <= match & adc_source_is_me_i &
			                 unit_control_reg_q[`CTL_ADC_TRIG_EN];
			unit_out_o    <= drive_hi;
			pin_out_o     <= unit_control_reg_q[`CTL_OPEN_DRAIN] ? 1'b0 : drive_hi;
			pin_oe_o      <= comparing & (~unit_control_reg_q[`CTL_OPEN_DRAIN] | ~drive_hi);
		end
	end

	// ------------------------------------------------------------------
	// register file and irq flag
	// ------------------------------------------------------------------
	// capture wins over a software byte write in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			unit_control_reg_q         <= `CTL_RESET;
			capture_input_select_reg_q <= 3'h0;
			timer_assign_sel_q         <= 2'h0;
			capture_compare_value_q    <= 16'h0000;
		end else begin
			if (wr_ctl) begin
				unit_control_reg_q <= wb_dat_i[7:0];
			end
			if (wr && hit_cap) begin
				capture_input_select_reg_q <= wb_dat_i[2:0];
			end
			if (wr && hit_tmr) begin
				timer_assign_sel_q <= (wb_dat_i[1:0] == 2'h3) ? 2'h0 : wb_dat_i[1:0];
			end
			if (cap_event) begin
				capture_compare_value_q <= sel_count;
			end else if (wr && hit_lo) begin
				capture_compare_value_q[7:0] <= wb_dat_i[7:0];
			end else if (wr && hit_hi) begin
				capture_compare_value_q[15:8] <= wb_dat_i[7:0];
			end
		end
	end

	// set wins over a software clear in the same cycle
	wire         flag_set   = cap_event | match;
	wire         flag_clr   = wr & hit_sts & ~wb_dat_i[`STS_IRQ_FLAG];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_flag_q <= 1'b0;
		end else if (flag_set) begin
			irq_flag_q <= 1'b1;
		end else if (flag_clr) begin
			irq_flag_q <= 1'b0;
		end
	end
	assign unit_irq_flag_o = irq_flag_q;

	// read mux and single-cycle answer
	wire [31:0]  rd_data    = hit_ctl ? {24'h0, unit_control_reg_q} :
	                          hit_cap ? {29'h0, capture_input_select_reg_q} :
	                          hit_lo  ? {24'h0, capture_compare_value_q[7:0]} :
	                          hit_hi  ? {24'h0, capture_compare_value_q[15:8]} :
	                          hit_tmr ? {30'h0, timer_assign_sel_q} :
	                          hit_sts ? {30'h0, out_latch_q, irq_flag_q} : 32'h0;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= req & mapped;
			wb_err_o <= req & ~mapped;
			wb_dat_o <= (req & mapped & ~wb_we_i) ? rd_data : 32'h0;
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_capture_copies_timer: assert property (cap_event |=>
		capture_compare_value_q == $past(sel_count))
		else $error("capture did not copy timer count");
	chk_flag_on_capture: assert property (cap_event |=> irq_flag_q)
		else $error("flag not set by capture");
	chk_flag_hw_never_clears: assert property (irq_flag_q && !flag_clr |=> irq_flag_q)
		else $error("flag cleared without software");
	chk_prescaler_cleared: assert property (!capturing |=> pre_cnt_q == 4'h0)
		else $error("prescaler not cleared");
	chk_timer_clear_modes: assert property (match && clr_mode |=> timer_clear_o != 3'h0)
		else $error("timer not cleared in clear mode");
	chk_no_clear_others: assert property (match && !clr_mode |=> timer_clear_o == 3'h0)
		else $error("timer cleared in wrong mode");
	chk_zero_ctl_latch: assert property (ctl_zero |=> !out_latch_q)
		else $error("zero control did not drop latch");
	chk_match_sets_flag: assert property (match |=> irq_flag_q)
		else $error("match did not set flag");
	chk_toggle_action: assert property (match && mode == `MODE_TOG && !ctl_zero
		|=> out_latch_q != $past(out_latch_q))
		else $error("toggle failed");
	chk_unit_out_follow: assert property (##1 unit_out_o == $past(drive_hi))
		else $error("unit output lags wrongly");
	chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");

	chk_err_one_cycle: assert property (wb_err_o |=> !wb_err_o)
		else $error("err held");
	chk_err_unmapped: assert property (req && !mapped |=> wb_err_o)
		else $error("unmapped access not refused");

	// byte writes land unless a capture takes the value in the same cycle
	chk_byte_write_low: assert property (wr && hit_lo && !cap_event |=>
		capture_compare_value_q[7:0] == $past(wb_dat_i[7:0]))
		else $error("low byte write lost");
	chk_byte_write_high: assert property (wr && hit_hi && !cap_event |=>
		capture_compare_value_q[15:8] == $past(wb_dat_i[7:0]))
		else $error("high byte write lost");
	chk_value_held: assert property (!cap_event && !(wr && (hit_lo || hit_hi)) |=>
		$stable(capture_compare_value_q))
		else $error("value changed without cause");

	// software clear only takes effect when no set competes
	chk_flag_sw_clear: assert property (flag_clr && !flag_set |=> !irq_flag_q)
		else $error("software clear ignored");

	// compare actions other than toggle
	chk_set_action: assert property (match && mode == `MODE_SET && !ctl_zero |=>
		out_latch_q)
		else $error("set action failed");
	chk_clr_action: assert property (match && mode == `MODE_CLR |=> !out_latch_q)
		else $error("clear action failed");
	chk_pulse_ends: assert property (pulse_q && sel_tick && !match |=> !pulse_q)
		else $error("pulse outlived its timer clock");

	// conversion trigger and timer clear pulses
	chk_adc_on_match: assert property (match && adc_source_is_me_i &&
		unit_control_reg_q[`CTL_ADC_TRIG_EN] |=> adc_trigger_o)
		else $error("match did not trigger conversion");
	chk_no_adc_idle: assert property (!match |=> !adc_trigger_o)
		else $error("conversion trigger without match");
	chk_clear_one_hot: assert property ($onehot0(timer_clear_o))
		else $error("more than one timer cleared");

	// pin driver: open drain never drives high, oe only in compare
	chk_open_drain_pin: assert property (unit_control_reg_q[`CTL_OPEN_DRAIN] |=>
		!pin_out_o)
		else $error("open drain drove high");
	chk_push_pull_oe: assert property (comparing && !unit_control_reg_q[`CTL_OPEN_DRAIN] |=>
		pin_oe_o)
		else $error("push-pull pin not driven");
	chk_oe_compare_only: assert property (!comparing |=> !pin_oe_o)
		else $error("pin driven outside compare");

	cov_capture: cover property (cap_event);
	cov_rise16: cover property (cap_event && mode == `MODE_CAP_RISE16);
	cov_open_drain: cover property (match && unit_control_reg_q[`CTL_OPEN_DRAIN]);
	cov_match_clear: cover property (match && clr_mode);
	cov_pulse: cover property (match && pulse_mode ##[1:40] !pulse_q);
endmodule : timer_capture_compare_unit

`default_nettype wire

// ==== timer_bank_model.sv ====
/* timer bank model: three 16-bit timers stepping at a quarter of clk_i.
   assumes the bench loads, runs and stops them. */
`timescale 1ns/10ps
`default_nettype none

module timer_bank_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        run_i,
	input  wire logic        load_i,
	input  wire logic [15:0] load_val_i,
	input  wire logic [2:0]  clear_i,
	output logic      [15:0] cnt_o [3],
	output logic      [2:0]  tick_o
);
	logic [1:0] div_q;

	// quarter-rate step: a raw-clock timer would break capture
	assign tick_o = {3{run_i && div_q == 2'h3}};

	// each timer loads its own offset so a wrong selection shows
	always_ff @(posedge clk_i) begin
		div_q <= rst_i ? 2'h0 : div_q + 2'h1;
		for (int i = 0; i < 3; i++) begin
			if (rst_i) cnt_o[i] <= 16'h0000;
			else if (load_i) cnt_o[i] <= load_val_i + 16'(i);
			else if (clear_i[i]) cnt_o[i] <= 16'h0000;
			else if (tick_o[i]) cnt_o[i] <= cnt_o[i] + 16'h0001;
		end
	end
endmodule : timer_bank_model

`default_nettype wire

// ==== timer_capture_compare_unit_tb.sv ====
/* bench for the capture/compare unit: wishbone master tasks, timer model
   and one task per scenario. assumes the defines header and package. */
`include "ccp_unit_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module timer_capture_compare_unit_tb;
	import ccp_unit_pkg::*;
	logic        clk, rst, cyc, stb, we, ack, err, run, load, adc_me, last_err;
	logic        adc_trig, irq, uout, pout, poe;
	logic [7:0]  adr, src;
	logic [31:0] dat_w, dat_r, rd;
	logic [15:0] load_val, cnt [3];
	logic [2:0]  tick, tclr;
	int          n_mismatch, compares, n_clr, n_adc, n_hi;

	timer_bank_model u_tmr (.clk_i(clk), .rst_i(rst), .run_i(run), .load_i(load),
		.load_val_i(load_val), .clear_i(tclr), .cnt_o(cnt), .tick_o(tick));

	timer_capture_compare_unit u_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat_w),
		.wb_sel_i(4'hF), .wb_dat_o(dat_r), .wb_ack_o(ack), .wb_err_o(err),
		.timer1_count_i(cnt[0]), .timer3_count_i(cnt[1]), .timer5_count_i(cnt[2]),
		.timer_tick_i(tick), .capture_pin_i(src[0]), .comparator_one_out_i(src[1]),
		.comparator_two_out_i(src[2]), .pin_change_event_i(src[3]),
		.logic_cell_one_out_i(src[4]), .logic_cell_two_out_i(src[5]),
		.logic_cell_three_out_i(src[6]), .logic_cell_four_out_i(src[7]),
		.adc_source_is_me_i(adc_me), .timer_clear_o(tclr), .adc_trigger_o(adc_trig),
		.unit_irq_flag_o(irq), .unit_out_o(uout), .pin_out_o(pout), .pin_oe_o(poe));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// classic cycle held until ack or err, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= d;
		// only the watchdog ends a wait for an answer that never comes
		do begin
			@(posedge clk);
		end while (ack !== 1'b1 && err !== 1'b1);
		rd = dat_r;
		last_err = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : wb

	task automatic edge_on(input int i, input logic v);
		src[i] <= v;
		repeat (8) @(posedge clk);
	endtask : edge_on

	task automatic ld(input logic [15:0] v);
		load_val <= v;
		load <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
	endtask : ld

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		check({irq, uout, poe}, 3'h0);
		wb(0, `OFS_CONTROL, 32'h0);
		check(rd, 32'h0);
		wb(0, 8'h40, 32'h0);
		check(last_err, 1'b1);
		wb(1, `OFS_CONTROL, 32'h8C);
		edge_on(0, 1);
		edge_on(0, 0);
		check(irq, 1'b0);
	endtask : t_reset

	// rise capture from the middle timer, fall ignored, then overwrite
	task automatic t_capture();
		ld(16'h12A0);
		wb(1, `OFS_TIMER_SEL, 32'h1);
		wb(1, `OFS_CONTROL, 32'h85);
		wb(1, `OFS_STATUS, 32'h0);
		edge_on(0, 1);
		check(irq, 1'b1);
		ld(16'h3450);
		edge_on(0, 0);
		wb(0, `OFS_VALUE_LOW, 32'h0);
		check(rd, 32'hA1);
		wb(0, `OFS_VALUE_HIGH, 32'h0);
		check(rd, 32'h12);
		edge_on(0, 1);
		wb(0, `OFS_VALUE_LOW, 32'h0);
		check(rd, 32'h51);
		wb(0, `OFS_VALUE_HIGH, 32'h0);
		check(rd, 32'h34);
		wb(0, `OFS_VALUE_LOW, 32'h0);
		check(rd, 32'h51);
		check(irq, 1'b1);
		wb(1, `OFS_STATUS, 32'h0);
		check(irq, 1'b0);
		edge_on(0, 0);
	endtask : t_capture

	// n-1 whole pulses give nothing, the nth qualifying edge captures
	task automatic t_mode(input logic [3:0] m, input int n);
		wb(1, `OFS_CONTROL, 32'h0);
		wb(1, `OFS_CONTROL, {24'h0, 4'h8, m});
		wb(1, `OFS_STATUS, 32'h0);
		repeat (n - 1) begin
			edge_on(0, 1);
			edge_on(0, 0);
		end
		check(irq, 1'b0);
		edge_on(0, 1);
		check(irq, m != `MODE_CAP_FALL);
		edge_on(0, 0);
		check(irq, 1'b1);
	endtask : t_mode

	// two counted edges then off and on: the count must restart
	task automatic t_pre_clear();
		repeat (2) begin
			edge_on(0, 1);
			edge_on(0, 0);
		end
		wb(1, `OFS_CONTROL, 32'h0);
		wb(1, `OFS_CONTROL, 32'h86);
		wb(1, `OFS_STATUS, 32'h0);
		repeat (3) begin
			edge_on(0, 1);
			edge_on(0, 0);
		end
		check(irq, 1'b0);
	endtask : t_pre_clear

	// pin edges must be ignored unless the pin is the chosen source
	task automatic t_sources();
		wb(1, `OFS_CONTROL, 32'h85);
		for (int s = 1; s < 8; s++) begin
			wb(1, `OFS_CAP_SEL, s);
			wb(1, `OFS_STATUS, 32'h0);
			edge_on(0, 1);
			edge_on(0, 0);
			check(irq, 1'b0);
			edge_on(s, 1);
			edge_on(s, 0);
			check(irq, 1'b1);
		end
	endtask : t_sources

	// timer frozen while armed so the match lands inside the window
	task automatic t_match(input logic [3:0] m, input logic od, input logic keep,
		input logic exp_out, input int exp_clr);
		run <= 1'b0;
		if (!keep) begin
			wb(1, `OFS_CONTROL, 32'h0);
			repeat (2) @(posedge clk);
			check(uout, 1'b0);
		end
		wb(1, `OFS_STATUS, 32'h0);
		wb(1, `OFS_CONTROL, {24'h0, 3'h5, od, m});
		n_clr = 0;
		n_adc = 0;
		n_hi = 0;
		run <= 1'b1;
		ld(16'h000C);
		repeat (24) @(posedge clk);
		check(uout, exp_out);
		check(n_clr, exp_clr);
		check({irq, n_adc[3:0]}, 5'h11);
		check({pout, poe}, {exp_out & ~od, ~(od & exp_out)});
		if (m >= `MODE_PULSE) check(n_hi > 0 && n_hi < 6, 1'b1);
	endtask : t_match

	// ------------------------------------------------------------
	// clock, monitors, watchdog and main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// counts one-cycle pulses and the cycles the output stays high
	always @(posedge clk) begin
		if (tclr[0] === 1'b1) n_clr++;
		if (adc_trig === 1'b1) n_adc++;
		if (uout === 1'b1) n_hi++;
	end

	task automatic tally_and_finish();
		if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : tally_and_finish

	// the scenarios need well under 10000 cycles
	initial begin
		#1ms;
		n_mismatch++;
		tally_and_finish();
	end

	initial begin
		{rst, cyc, stb, we, run, load, adc_me} = 7'h40;
		{adr, src, dat_w, load_val} = 64'h0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_capture();
		t_mode(`MODE_CAP_RISE, 1);
		t_mode(`MODE_CAP_FALL, 1);
		t_mode(`MODE_CAP_ANY, 1);
		t_mode(`MODE_CAP_RISE4, 4);
		t_pre_clear();
		t_mode(`MODE_CAP_RISE16, 16);
		t_sources();
		wb(1, `OFS_TIMER_SEL, 32'h0);
		wb(1, `OFS_VALUE_LOW, 32'h10);
		wb(1, `OFS_VALUE_HIGH, 32'h0);
		adc_me <= 1'b1;
		t_match(`MODE_TOG_CLR, 1'b0, 1'b0, 1'b1, 1);
		t_match(`MODE_TOG, 1'b1, 1'b0, 1'b1, 0);
		t_match(`MODE_SET, 1'b0, 1'b0, 1'b1, 0);
		t_match(`MODE_CLR, 1'b0, 1'b1, 1'b0, 0);
		t_match(`MODE_PULSE, 1'b0, 1'b0, 1'b0, 0);
		t_match(`MODE_PULSE_CLR, 1'b0, 1'b0, 1'b0, 1);
		tally_and_finish();
	end
endmodule : timer_capture_compare_unit_tb

`default_nettype wire
